// >>> src/hs_irq_pkg.sv
// Constants and carrier types for the switch select and interrupt mask bank.
package hs_irq_pkg;

  localparam logic [6:0]  HS_SELECT_ADDR  = 7'h08;
  localparam logic [6:0]  IRQ_MASK_ADDR   = 7'h09;
  localparam logic [11:0] HS_SELECT_RESET = 12'h000;
  localparam logic [8:0]  IRQ_MASK_POR    = 9'h140;

  localparam int NUM_SWITCHES = 3;
  localparam int FIELD_W      = 4;
  localparam int REPEAT_BIT   = 8;
  localparam int WD_OFF_BIT   = 7;
  localparam int WD_IRQ_BIT   = 6;
  localparam int CRC_IRQ_BIT  = 5;
  localparam int GROUP_MSB    = 4;

  localparam logic [3:0] CODE_OFF    = 4'h0;
  localparam logic [3:0] CODE_ON     = 4'h1;
  localparam logic [3:0] CODE_TIMER_ONE_DRIVE = 4'h2;
  localparam logic [3:0] CODE_TIMER_TWO_DRIVE = 4'h3;
  localparam logic [1:0] CODE_PWM_HI = 2'h1;
  localparam logic [3:0] CODE_WAKE   = 4'h8;

  localparam int CLK_PERIOD_NS = 4;
  localparam int PULSE_LOW_NS  = 100;
  localparam int PULSE_GAP_NS  = 100;
  localparam int REPEAT_NS     = 10000;
  localparam int PULSE_LOW_CYCLES =
    (PULSE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_GAP_CYCLES =
    (PULSE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REPEAT_CYCLES = REPEAT_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [4:0] group;
    logic       spi_crc_fail;
    logic       wd_fail;
  } irq_events_s;

  typedef struct packed {
    logic [2:0]      valid;
    logic [2:0][3:0] value;
  } hw_select_s;

endpackage : hs_irq_pkg

// >>> src/irq_pulse_gen.sv
// Low-active pulse generator with a queue of one for back-to-back events.
`timescale 1ns/1ps
`default_nettype none
module irq_pulse_gen
  import hs_irq_pkg::*;
#(
  parameter int LOW_CYCLES = 25,
  parameter int GAP_CYCLES = 25
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic trigger_in,
  output var  logic pulse_n_out
);

  typedef enum logic [1:0] {IDLE, LOW, GAP} pulse_state_e;

  pulse_state_e state;
  logic [7:0]   count;
  logic         queued;

  wire logic low_done = count == 8'(LOW_CYCLES - 1);
  wire logic gap_done = count == 8'(GAP_CYCLES - 1);

  // An event that lands while a pulse or its gap is running is queued, but the queue holds one,
  // so several events in that window share a single following falling edge.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state       <= IDLE;
      count       <= 8'h00;
      queued      <= 1'b0;
      pulse_n_out <= 1'b1;
    end else begin
      count <= count + 8'h01;
      case (state)
        IDLE: begin
          count <= 8'h00;
          if (trigger_in) begin
            state       <= LOW;
            pulse_n_out <= 1'b0;
          end
        end
        LOW: begin
          queued <= queued | trigger_in;
          if (low_done) begin
            state       <= GAP;
            count       <= 8'h00;
            pulse_n_out <= 1'b1;
          end
        end
        GAP: begin
          queued <= queued | trigger_in;
          if (gap_done) begin
            count <= 8'h00;
            if (queued || trigger_in) begin
              state       <= LOW;
              queued      <= 1'b0;
              pulse_n_out <= 1'b0;
            end else begin
              state <= IDLE;
            end
          end
        end
        default: begin
          state       <= IDLE;
          pulse_n_out <= 1'b1;
        end
      endcase
    end
  end

endmodule : irq_pulse_gen
`default_nettype wire

// >>> src/high_side_select_and_irq_mask.sv
// Switch source select and interrupt mask registers with their output logic.
`timescale 1ns/1ps
`default_nettype none
module high_side_select_and_irq_mask
  import hs_irq_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        restart_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  input  wire logic [6:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  output var  logic [15:0] reg_rdata_out,
  input  wire hw_select_s  hw_select_in,
  input  wire logic        timer_one_drive_in,
  input  wire logic        timer_two_drive_in,
  input  wire logic [3:0]  internal_pwm_in,
  input  wire logic        wake_sync_input_in,
  output var  logic [2:0]  switch_drive_out,
  input  wire irq_events_s irq_events_in,
  input  wire logic        irq_pending_in,
  input  wire logic        devmode_in,
  output var  logic        watchdog_enable_out,
  output var  logic        interrupt_out_n
);

  logic [2:0][3:0] switch_select;
  logic [8:0]      irq_mask;
  logic            irq_request;
  logic [11:0]     repeat_count;

  wire logic hs_hit   = reg_addr_in == HS_SELECT_ADDR;
  wire logic mask_hit = reg_addr_in == IRQ_MASK_ADDR;
  wire logic hs_write   = reg_write_in && hs_hit;
  wire logic mask_write = reg_write_in && mask_hit;

  wire logic periodic_irq_repeat       = irq_mask[REPEAT_BIT];
  wire logic devmode_watchdog_off      = irq_mask[WD_OFF_BIT];
  wire logic devmode_watchdog_fail_irq = irq_mask[WD_IRQ_BIT];
  wire logic spi_crc_fail_irq          = irq_mask[CRC_IRQ_BIT];

  wire logic [4:0] group_hits = irq_events_in.group & irq_mask[GROUP_MSB:0];
  wire logic wd_hit  = irq_events_in.wd_fail && devmode_in &&
                       devmode_watchdog_fail_irq;
  wire logic crc_hit = irq_events_in.spi_crc_fail && spi_crc_fail_irq;
  wire logic repeat_run  = periodic_irq_repeat && irq_pending_in;
  wire logic repeat_fire = repeat_run &&
                           repeat_count == 12'(REPEAT_CYCLES - 1);
  // Events are taken as pulses, not status levels, so a status bit that was
  // already set never hides a fresh event.
  wire logic next_irq_request = (|group_hits) || wd_hit || crc_hit ||
                                repeat_fire;

  wire logic [15:0] next_rdata =
    hs_hit   ? {4'h0, switch_select} :
    mask_hit ? {7'h00, irq_mask} : 16'h0000;

  // Switch fields: restart clears, hardware update wins over a host write.
  wire logic [2:0] next_drive;

  genvar i;
  generate
    for (i = 0; i < NUM_SWITCHES; i++) begin : g_switch
      wire logic [3:0] code = switch_select[i];
      // Codes 01xx pick the internal high-side PWM generators only.
      wire logic pwm_pick = code[3:2] == CODE_PWM_HI;
      assign next_drive[i] =
        code == CODE_ON     ? 1'b1 :
        code == CODE_TIMER_ONE_DRIVE ? timer_one_drive_in :
        code == CODE_TIMER_TWO_DRIVE ? timer_two_drive_in :
        pwm_pick            ? internal_pwm_in[code[1:0]] :
        code == CODE_WAKE   ? wake_sync_input_in : 1'b0;
    end
  endgenerate

  // One process owns all three fields, so no bit has a second writer.
  always_ff @(posedge clk_in) begin
    if (rst_in || restart_in) begin
      switch_select    <= HS_SELECT_RESET;
      switch_drive_out <= 3'h0;
    end else begin
      switch_drive_out <= next_drive;
      for (int j = 0; j < NUM_SWITCHES; j++) begin
        if (hw_select_in.valid[j]) begin
          switch_select[j] <= hw_select_in.value[j];
        end else if (hs_write) begin
          switch_select[j] <= reg_wdata_in[j*FIELD_W +: FIELD_W];
        end
      end
    end
  end

  // Restart keeps the mask; only the reserved bits, never stored, clear.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_mask <= IRQ_MASK_POR;
    end else if (mask_write) begin
      irq_mask <= reg_wdata_in[8:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_read_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      repeat_count <= 12'h000;
    end else if (!repeat_run || repeat_fire) begin
      repeat_count <= 12'h000;
    end else begin
      repeat_count <= repeat_count + 12'h001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_request         <= 1'b0;
      watchdog_enable_out <= 1'b1;
    end else begin
      irq_request         <= next_irq_request;
      watchdog_enable_out <= !(devmode_in && devmode_watchdog_off);
    end
  end

  irq_pulse_gen #(
    .LOW_CYCLES (PULSE_LOW_CYCLES),
    .GAP_CYCLES (PULSE_GAP_CYCLES)
  ) u_pulse (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .trigger_in  (irq_request),
    .pulse_n_out (interrupt_out_n)
  );

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  hs_reserved_zero_a: assert property (
    reg_read_in && hs_hit |=> reg_rdata_out[15:12] == 4'h0)
    else $error("switch select reserved bits not zero");

  mask_reserved_zero_a: assert property (
    reg_read_in && mask_hit |=> reg_rdata_out[15:9] == 7'h00)
    else $error("mask reserved bits not zero");

  restart_clears_sel_a: assert property (
    restart_in |=> switch_select == '0 ##1 switch_drive_out == 3'h0)
    else $error("restart did not clear switch select");

  restart_keeps_mask_a: assert property (
    restart_in && !mask_write |=> irq_mask == $past(irq_mask))
    else $error("restart changed the mask");

  hw_update_wins_a: assert property (
    hw_select_in.valid[0] && !restart_in |=>
      switch_select[0] == $past(hw_select_in.value[0]))
    else $error("hardware update not returned");

  switch_on_drive_a: assert property (
    switch_select[1] == CODE_ON && !restart_in |=> switch_drive_out[1])
    else $error("switch coded on is not driven");

  pwm_follow_a: assert property (
    switch_select[2] == 4'h7 && !restart_in |=>
      switch_drive_out[2] == $past(internal_pwm_in[3]))
    else $error("switch does not follow internal PWM four");

  wake_follow_a: assert property (
    switch_select[0] == CODE_WAKE && !restart_in |=>
      switch_drive_out[0] == $past(wake_sync_input_in))
    else $error("switch does not follow the wake input");

  reserved_code_off_a: assert property (
    switch_select[0] > CODE_WAKE && !restart_in |=> !switch_drive_out[0])
    else $error("reserved code drives the switch");

  wd_devmode_off_a: assert property (
    devmode_in && devmode_watchdog_off |=> !watchdog_enable_out)
    else $error("watchdog not disabled in development mode");

  wd_fail_event_a: assert property (
    irq_events_in.wd_fail && devmode_in && devmode_watchdog_fail_irq
      |=> irq_request)
    else $error("watchdog failure raised no event");

  crc_masked_off_a: assert property (
    irq_events_in.spi_crc_fail && !spi_crc_fail_irq &&
      irq_events_in.group == 5'h00 && !irq_events_in.wd_fail && !repeat_run
      |=> !irq_request)
    else $error("masked CRC failure raised an event");

  group_event_a: assert property (
    irq_events_in.group[4] && irq_mask[4] |=> irq_request)
    else $error("bridge driver event raised no request");

  request_pulses_a: assert property (
    irq_request |-> ##[1:110] !interrupt_out_n)
    else $error("request did not pulse the interrupt output");

  repeat_period_a: assert property (
    repeat_run |-> repeat_count < 12'(REPEAT_CYCLES))
    else $error("repeat counter overran its period");

  no_repeat_when_off_a: assert property (
    !periodic_irq_repeat |-> !repeat_fire ##1 repeat_count == 12'h000)
    else $error("repeat ran with periodic repetition off");

  repeat_request_a: assert property (
    repeat_fire |=> irq_request)
    else $error("repeat period raised no request");

  cov_repeat: cover property (repeat_fire);
  cov_back_to_back: cover property (irq_request ##1 irq_request);
  cov_hw_and_write: cover property (hw_select_in.valid[0] && hs_write);
  cov_restart: cover property (restart_in && irq_mask != IRQ_MASK_POR);

endmodule : high_side_select_and_irq_mask
`default_nettype wire

// >>> tb/host_model.sv
// Host microcontroller model driving the decoded register port.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        clk_in,
  output var  logic        wr_out,
  output var  logic        rd_out,
  output var  logic [6:0]  addr_out,
  output var  logic [15:0] wdata_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 7'h00;
    wdata_out = 16'h0000;
  end
  // Released data is inverted so a stale word can never pass for a write.
  task automatic write_reg(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask : write_reg
  task automatic read_reg(input logic [6:0] a);
    @(posedge clk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out <= 1'b0;
  endtask : read_reg
endmodule : host_model
`default_nettype wire

// >>> tb/high_side_select_and_irq_mask_bench.sv
// Self-checking bench for the switch select and interrupt mask bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  err_total++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module high_side_select_and_irq_mask_bench;
  import hs_irq_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        restart_in = 1'b0;
  logic        wr, rd;
  logic [6:0]  addr;
  logic [15:0] wdata, rdata;
  hw_select_s  hw_sel = '0;
  logic [6:0]  src = 7'h00;
  logic [2:0]  drive;
  irq_events_s ev = '0;
  logic        pending = 1'b0;
  logic        devmode = 1'b0;
  logic        wd_en, irq_n;
  int          err_total = 0;
  int          cmp_count = 0;
  bit          fell;

  host_model host_u (.clk_in(clk_in), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .wdata_out(wdata));
  high_side_select_and_irq_mask dut_u (.clk_in(clk_in), .rst_in(rst_in),
    .restart_in(restart_in), .reg_write_in(wr), .reg_read_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .hw_select_in(hw_sel), .timer_one_drive_in(src[0]),
    .timer_two_drive_in(src[1]), .internal_pwm_in(src[5:2]),
    .wake_sync_input_in(src[6]), .switch_drive_out(drive),
    .irq_events_in(ev), .irq_pending_in(pending), .devmode_in(devmode),
    .watchdog_enable_out(wd_en), .interrupt_out_n(irq_n));

  initial begin
    forever #2 clk_in = ~clk_in;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
    host_u.read_reg(a);
    #1 `CHK("read data", e, rdata)
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : wait_cyc

  // Looks for a falling output within lim cycles, then sits out pulse and gap.
  task automatic irq_seen(input int lim);
    int n;
    fell = 0;
    for (n = 0; n < lim && !fell; n++) begin
      wait_cyc(1);
      if (irq_n === 1'b0) fell = 1;
    end
    if (fell) wait_cyc(PULSE_LOW_CYCLES + PULSE_GAP_CYCLES + 4);
  endtask : irq_seen

  task automatic pulse_ev(input int m);
    @(posedge clk_in);
    ev <= irq_events_s'(m < 5 ? 7'h04 << m : (m == 5 ? 7'h02 : 7'h01));
    @(posedge clk_in);
    ev <= '0;
    irq_seen(6);
  endtask : pulse_ev

  task automatic test_regs();
    rd_chk(HS_SELECT_ADDR, 16'h0000);
    rd_chk(IRQ_MASK_ADDR, 16'h0140);
    host_u.write_reg(HS_SELECT_ADDR, 16'hffff);
    rd_chk(HS_SELECT_ADDR, 16'h0fff);
    host_u.write_reg(IRQ_MASK_ADDR, 16'hffff);
    rd_chk(IRQ_MASK_ADDR, 16'h01ff);
    host_u.write_reg(7'h0a, 16'h1234);
    rd_chk(7'h0a, 16'h0000);
    @(posedge clk_in);
    restart_in <= 1'b1;
    @(posedge clk_in);
    restart_in <= 1'b0;
    rd_chk(HS_SELECT_ADDR, 16'h0000);
    rd_chk(IRQ_MASK_ADDR, 16'h01ff);
    host_u.write_reg(HS_SELECT_ADDR, 16'h0111);
    @(posedge clk_in);
    hw_sel <= '{valid: 3'b011, value: {4'h0, 4'h7, 4'h8}};
    @(posedge clk_in);
    hw_sel <= '0;
    rd_chk(HS_SELECT_ADDR, 16'h0178);
  endtask : test_regs

  // Two opposite source patterns show each of codes 2 to 8 driving its expected source bit both high and low.
  task automatic test_codes();
    logic [6:0] p;
    logic       e;
    for (int c = 0; c < 10; c++) begin
      for (int k = 0; k < 2; k++) begin
        p = k ? 7'h2a : 7'h55;
        e = (c == 1) || (c >= 2 && c <= 8 && p[c - 2]);
        @(posedge clk_in);
        src <= p;
        host_u.write_reg(HS_SELECT_ADDR, {4'h0, 4'(c), 4'(c), 4'(c)});
        wait_cyc(3);
        `CHK("switch drive", {3{e}}, drive)
      end
    end
  endtask : test_codes

  task automatic test_watchdog();
    host_u.write_reg(IRQ_MASK_ADDR, 16'h0080);
    wait_cyc(3);
    `CHK("watchdog enable", 1'b1, wd_en)
    @(posedge clk_in);
    devmode <= 1'b1;
    wait_cyc(3);
    `CHK("watchdog enable", 1'b0, wd_en)
    host_u.write_reg(IRQ_MASK_ADDR, 16'h0000);
    wait_cyc(3);
    `CHK("watchdog enable", 1'b1, wd_en)
  endtask : test_watchdog

  task automatic test_events();
    for (int m = 0; m < 7; m++) begin
      host_u.write_reg(IRQ_MASK_ADDR, 16'h0001 << m);
      repeat (2) begin
        pulse_ev(m);
        `CHK("event pulse", 1'b1, fell)
      end
      host_u.write_reg(IRQ_MASK_ADDR, 16'h007f & ~(16'h0001 << m));
      pulse_ev(m);
      `CHK("masked event", 1'b0, fell)
    end
  endtask : test_events

  task automatic test_repeat();
    host_u.write_reg(IRQ_MASK_ADDR, 16'h0100);
    @(posedge clk_in);
    pending <= 1'b1;
    repeat (2) begin
      irq_seen(REPEAT_CYCLES + 100);
      `CHK("repeat pulse", 1'b1, fell)
    end
    host_u.write_reg(IRQ_MASK_ADDR, 16'h0000);
    irq_seen(REPEAT_CYCLES + 100);
    `CHK("no repeat", 1'b0, fell)
  endtask : test_repeat

  initial begin
    #(4 * 40000);
    err_total++;
    finish_test();
  end

  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    test_regs();
    test_codes();
    test_watchdog();
    test_events();
    test_repeat();
    finish_test();
  end
endmodule : high_side_select_and_irq_mask_bench
`default_nettype wire
